// ==== rtl/gr_operand_unit.sv ====
// operand addressing and execution for register/memory instructions
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module gr_operand_unit
  import gr_addr_pkg::*;
#(
  parameter int MEM_WORDS = 1 << MADDR_W
) (
  input  wire logic          core_clk_in,
  input  wire logic          resetn_in,
  input  wire logic          clk_en_in,
  input  wire logic          instr_valid_in,
  input  wire instr_t        instr_in,
  input  wire logic          mem_ptr_enable_in,
  input  wire logic          host_we_in,
  input  wire maddr_t        host_addr_in,
  input  wire logic [NIB_W-1:0] host_wdata_in,
  output logic [NIB_W-1:0]   host_rdata_out,
  output logic               carry_flag_out,
  output logic [ROWPTR_W-1:0] gr_row_pointer_out,
  output logic [BANK_W-1:0]  bank_out,
  output maddr_t             gr_addr_out,
  output maddr_t             mem_addr_out,
  output logic               done_out
);
  logic [NIB_W-1:0]    mem [MEM_WORDS];
  logic [ROWPTR_W-1:0] gr_row_pointer;
  logic [BANK_W-1:0]   bank;
  logic [BANK_W+ROW_W-1:0] mem_row_pointer;
  logic                carry_flag;
  maddr_t              gr_addr;
  maddr_t              m_addr;
  maddr_t              ind_addr;
  logic [NIB_W-1:0]    r_word;
  logic [NIB_W-1:0]    m_word;
  logic [NIB_W-1:0]    alu_res;
  logic                alu_cy;
  logic                alu_cy_we;
  logic                go;

  assign go = clk_en_in && instr_valid_in;

  // the register row only comes from the low three pointer bits; high bits stay 0
  always_comb begin
    gr_addr.bank = GR_BANK;
    gr_addr.row  = gr_row_pointer[ROW_W-1:0];
    gr_addr.col  = instr_in.r_field[NIB_W-1:0];
  end

  always_comb begin
    m_addr.bank = bank;
    m_addr.row  = instr_in.m_row;
    m_addr.col  = instr_in.m_col;
  end

  assign r_word = mem[gr_addr];
  assign m_word = mem[m_addr];

  always_comb begin
    if (mem_ptr_enable_in) begin
      ind_addr.bank = mem_row_pointer[BANK_W+ROW_W-1:ROW_W];
      ind_addr.row  = mem_row_pointer[ROW_W-1:0];
    end else begin
      ind_addr.bank = bank;
      ind_addr.row  = instr_in.m_row;
    end
    ind_addr.col = r_word;
  end

  gr_alu u_alu (
    .op_in        (instr_in.op),
    .r_in         (r_word),
    .m_in         (m_word),
    .carry_in     (carry_flag),
    .result_out   (alu_res),
    .carry_out    (alu_cy),
    .carry_we_out (alu_cy_we)
  );

  // single write port; the op set has no register-with-immediate form
  // host writes also wait for the clock enable, so a freeze holds the whole memory
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
    end else if (clk_en_in && host_we_in) begin
      mem[host_addr_in] <= host_wdata_in;
    end else if (go) begin
      case (instr_in.op)
        OP_ADD, OP_ADD_WITH_CARRY, OP_SUB, OP_SUB_WITH_BORROW, OP_AND, OP_OR, OP_XOR,
        OP_LOAD_TO_REGISTER, OP_ROTATE_RIGHT_THROUGH_CARRY: begin
          mem[gr_addr] <= alu_res;
        end
        OP_STORE_FROM_REGISTER: mem[m_addr] <= r_word;
        OP_MOV_IND_TO: mem[ind_addr] <= m_word;
        OP_MOV_IND_FROM: mem[m_addr] <= mem[ind_addr];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      carry_flag <= 1'b0;
    end else if (go && alu_cy_we) begin
      carry_flag <= alu_cy;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      gr_row_pointer  <= ROWPTR_RESET;
      bank            <= BANK_RESET;
      mem_row_pointer <= '0;
    end else if (go) begin
      case (instr_in.op)
        OP_SET_ROW_PTR: gr_row_pointer <= {4'h0, instr_in.imm[ROW_W-1:0]};
        OP_SET_BANK: bank <= instr_in.imm[BANK_W-1:0];
        OP_SET_MEM_PTR: mem_row_pointer <= instr_in.imm[BANK_W+ROW_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      host_rdata_out     <= '0;
      carry_flag_out     <= 1'b0;
      gr_row_pointer_out <= ROWPTR_RESET;
      bank_out           <= BANK_RESET;
      gr_addr_out        <= '0;
      mem_addr_out       <= '0;
      done_out           <= 1'b0;
    end else if (clk_en_in) begin
      host_rdata_out     <= mem[host_addr_in];
      carry_flag_out     <= carry_flag;
      gr_row_pointer_out <= gr_row_pointer;
      bank_out           <= bank;
      gr_addr_out        <= gr_addr;
      mem_addr_out       <= (instr_in.op == OP_MOV_IND_TO) ? ind_addr : m_addr;
      done_out           <= go;
    end
  end

  a_row_high_zero: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    gr_row_pointer[ROWPTR_W-1:ROW_W] == 4'h0) else $error("row pointer high bits not zero");
  a_gr_bank_zero: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    gr_addr.bank == GR_BANK && gr_addr.row == gr_row_pointer[ROW_W-1:0]) else $error("register address wrong");
  a_add_result: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    go && !host_we_in && instr_in.op == OP_ADD |=> mem[$past(gr_addr)] == $past(r_word + m_word))
    else $error("add result wrong");
  a_load_copy: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    go && !host_we_in && instr_in.op == OP_LOAD_TO_REGISTER |=> mem[$past(gr_addr)] == $past(m_word))
    else $error("load result wrong");
  a_freeze_carry: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    !clk_en_in |=> carry_flag == $past(carry_flag)) else $error("carry moved while frozen");
  a_rotate_carry: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    go && instr_in.op == OP_ROTATE_RIGHT_THROUGH_CARRY |=> carry_flag == $past(r_word[0]))
    else $error("rotate carry wrong");
  a_ind_column: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    ind_addr.col == r_word) else $error("indirect column wrong");
  a_ind_row_off: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    !mem_ptr_enable_in |-> ind_addr.row == instr_in.m_row && ind_addr.bank == bank)
    else $error("indirect row wrong");
  a_ind_row_on: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    mem_ptr_enable_in |-> {ind_addr.bank, ind_addr.row} == mem_row_pointer) else $error("pointer addr wrong");
  a_done_follow: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    clk_en_in |=> done_out == $past(go)) else $error("done pulse wrong");
  c_add: cover property (@(posedge core_clk_in) go && instr_in.op == OP_ADD);
  c_ind: cover property (@(posedge core_clk_in) go && instr_in.op == OP_MOV_IND_TO && mem_ptr_enable_in);
  c_rot: cover property (@(posedge core_clk_in) go && instr_in.op == OP_ROTATE_RIGHT_THROUGH_CARRY);
endmodule
`default_nettype wire

// ==== rtl/gr_addr_pkg.sv ====
// shared constants and types for register/memory operand addressing
package gr_addr_pkg;
  localparam int NIB_W      = 4;
  localparam int ROW_W      = 3;
  localparam int BANK_W     = 2;
  localparam int MADDR_W    = BANK_W + ROW_W + NIB_W;
  localparam int ROWPTR_W   = 7;
  localparam int GR_WORDS   = 16;
  localparam logic [BANK_W-1:0] GR_BANK  = 2'h0;
  localparam logic [ROWPTR_W-1:0] ROWPTR_RESET = 7'h00;
  localparam logic [BANK_W-1:0]   BANK_RESET   = 2'h0;
  localparam logic [ROW_W-1:0]    MEMPTR_RESET = 3'h0;

  typedef enum logic [3:0] {
    OP_NOP,
    OP_ADD,
    OP_ADD_WITH_CARRY,
    OP_SUB,
    OP_SUB_WITH_BORROW,
    OP_AND,
    OP_OR,
    OP_XOR,
    OP_LOAD_TO_REGISTER,
    OP_STORE_FROM_REGISTER,
    OP_MOV_IND_TO,
    OP_MOV_IND_FROM,
    OP_ROTATE_RIGHT_THROUGH_CARRY,
    OP_SET_ROW_PTR,
    OP_SET_BANK,
    OP_SET_MEM_PTR
  } op_t;

  typedef struct packed {
    op_t               op;
    logic [ROW_W-1:0]  m_row;
    logic [NIB_W-1:0]  m_col;
    logic [6:0]        r_field;
    logic [ROWPTR_W-1:0] imm;
  } instr_t;

  typedef struct packed {
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0]  row;
    logic [NIB_W-1:0]  col;
  } maddr_t;
endpackage

// ==== rtl/gr_alu.sv ====
// four-bit ALU for register/memory instructions
`timescale 1ns/1ns
`default_nettype none
module gr_alu
  import gr_addr_pkg::*;
(
  input  wire op_t              op_in,
  input  wire logic [NIB_W-1:0] r_in,
  input  wire logic [NIB_W-1:0] m_in,
  input  wire logic             carry_in,
  output logic [NIB_W-1:0]      result_out,
  output logic                  carry_out,
  output logic                  carry_we_out
);
  logic [NIB_W:0] sum;

  always_comb begin
    sum          = '0;
    result_out   = r_in;
    carry_out    = carry_in;
    carry_we_out = 1'b0;
    case (op_in)
      OP_ADD: begin
        sum = {1'b0, r_in} + {1'b0, m_in};
        result_out = sum[NIB_W-1:0];
        carry_out = sum[NIB_W];
        carry_we_out = 1'b1;
      end
      OP_ADD_WITH_CARRY: begin
        sum = {1'b0, r_in} + {1'b0, m_in} + {{NIB_W{1'b0}}, carry_in};
        result_out = sum[NIB_W-1:0];
        carry_out = sum[NIB_W];
        carry_we_out = 1'b1;
      end
      OP_SUB: begin
        sum = {1'b0, r_in} - {1'b0, m_in};
        result_out = sum[NIB_W-1:0];
        carry_out = sum[NIB_W];
        carry_we_out = 1'b1;
      end
      OP_SUB_WITH_BORROW: begin
        sum = {1'b0, r_in} - {1'b0, m_in} - {{NIB_W{1'b0}}, carry_in};
        result_out = sum[NIB_W-1:0];
        carry_out = sum[NIB_W];
        carry_we_out = 1'b1;
      end
      OP_AND: result_out = r_in & m_in;
      OP_OR: result_out = r_in | m_in;
      OP_XOR: result_out = r_in ^ m_in;
      OP_LOAD_TO_REGISTER: result_out = m_in;
      OP_ROTATE_RIGHT_THROUGH_CARRY: begin
        result_out = {carry_in, r_in[NIB_W-1:1]};
        carry_out = r_in[0];
        carry_we_out = 1'b1;
      end
      default: result_out = r_in;
    endcase
  end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the register/memory operand unit
`timescale 1ns/1ns
`default_nettype none
module tb;
  import gr_addr_pkg::*;
  typedef struct packed {
    op_t        op;
    logic [3:0] r;
    logic [3:0] m;
    logic       c;
    logic [3:0] er;
    logic [3:0] em;
    logic       ec;
  } row_t;
  logic                core_clk_in = 1'b0;
  logic                resetn_in = 1'b0;
  logic                clk_en_in = 1'b1;
  logic                instr_valid_in = 1'b0;
  instr_t              instr_in = '0;
  logic                mem_ptr_enable_in = 1'b0;
  logic                host_we_in = 1'b0;
  maddr_t              host_addr_in = '0;
  logic [NIB_W-1:0]    host_wdata_in = '0;
  logic [NIB_W-1:0]    host_rdata_out;
  logic                carry_flag_out;
  logic [ROWPTR_W-1:0] gr_row_pointer_out;
  logic [BANK_W-1:0]   bank_out;
  maddr_t              gr_addr_out;
  maddr_t              mem_addr_out;
  logic                done_out;
  maddr_t              ga;
  maddr_t              ma;
  logic [3:0]          d;
  int                  miscompares = 0;
  int                  samples_checked = 0;
  // register word A, memory word 6, carry in, then result, memory after, carry after
  row_t rows [10] = '{
    '{OP_ADD, 4'hA, 4'h6, 1'b0, 4'h0, 4'h6, 1'b1},
    '{OP_ADD_WITH_CARRY, 4'hA, 4'h6, 1'b1, 4'h1, 4'h6, 1'b1},
    '{OP_SUB, 4'hA, 4'h6, 1'b0, 4'h4, 4'h6, 1'b0},
    '{OP_SUB_WITH_BORROW, 4'hA, 4'h6, 1'b1, 4'h3, 4'h6, 1'b0},
    '{OP_AND, 4'hA, 4'h6, 1'b1, 4'h2, 4'h6, 1'b1},
    '{OP_OR, 4'hA, 4'h6, 1'b1, 4'hE, 4'h6, 1'b1},
    '{OP_XOR, 4'hA, 4'h6, 1'b1, 4'hC, 4'h6, 1'b1},
    '{OP_LOAD_TO_REGISTER, 4'hA, 4'h6, 1'b0, 4'h6, 4'h6, 1'b0},
    '{OP_STORE_FROM_REGISTER, 4'hA, 4'h6, 1'b0, 4'hA, 4'hA, 1'b0},
    '{OP_ROTATE_RIGHT_THROUGH_CARRY, 4'hA, 4'h6, 1'b1, 4'hD, 4'h6, 1'b0}};

  gr_operand_unit u_dut (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .clk_en_in(clk_en_in),
    .instr_valid_in(instr_valid_in), .instr_in(instr_in), .mem_ptr_enable_in(mem_ptr_enable_in),
    .host_we_in(host_we_in), .host_addr_in(host_addr_in), .host_wdata_in(host_wdata_in),
    .host_rdata_out(host_rdata_out), .carry_flag_out(carry_flag_out),
    .gr_row_pointer_out(gr_row_pointer_out), .bank_out(bank_out),
    .gr_addr_out(gr_addr_out), .mem_addr_out(mem_addr_out), .done_out(done_out));

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input maddr_t a, input logic [3:0] v);
    @(posedge core_clk_in);
    host_we_in <= 1'b1;
    host_addr_in <= a;
    host_wdata_in <= v;
    @(posedge core_clk_in);
    host_we_in <= 1'b0;
  endtask
  task automatic rd(input maddr_t a);
    @(posedge core_clk_in);
    host_addr_in <= a;
    @(posedge core_clk_in);
    #1 d = host_rdata_out;
  endtask
  // leaves the caller 1 ns after the taking edge, inside the done cycle
  task automatic ex(input op_t o, input logic [2:0] mr, input logic [3:0] mc, input logic [6:0] rf,
                    input logic [6:0] im);
    @(posedge core_clk_in);
    instr_valid_in <= 1'b1;
    instr_in <= '{o, mr, mc, rf, im};
    @(posedge core_clk_in);
    instr_valid_in <= 1'b0;
    #1;
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    forever #5 core_clk_in = ~core_clk_in;
  end
  initial begin
    #30000;
    miscompares++;
    close_out();
  end

  initial begin
    repeat (16) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    #1;
    chk({carry_flag_out, gr_row_pointer_out, bank_out}, 10'h000);
    ex(OP_SET_BANK, 3'h0, 4'h0, 7'h00, 7'h01);
    for (int i = 0; i < 10; i++) begin
      ga = '{GR_BANK, 3'(i), 4'(i)};
      ma = '{2'h1, 3'(i + 1), 4'(i + 6)};
      // upper pointer bits offered as ones must not reach the row
      ex(OP_SET_ROW_PTR, 3'h0, 4'h0, 7'h00, {4'hF, 3'(i)});
      wr('{GR_BANK, 3'(i), 4'hF}, {3'h0, rows[i].c});
      ex(OP_ROTATE_RIGHT_THROUGH_CARRY, 3'h0, 4'h0, 7'h0F, 7'h00);
      chk(gr_row_pointer_out, {4'h0, 3'(i)});
      wr(ga, rows[i].r);
      wr(ma, rows[i].m);
      ex(rows[i].op, ma.row, ma.col, {3'h5, 4'(i)}, 7'h00);
      chk(done_out, 1'b1);
      chk(gr_addr_out, ga);
      chk(mem_addr_out, ma);
      rd(ga);
      chk(d, rows[i].er);
      rd(ma);
      chk(d, rows[i].em);
      chk(carry_flag_out, rows[i].ec);
      $display("case %0d finished", i);
    end
    chk(bank_out, 2'h1);
    ex(OP_SET_MEM_PTR, 3'h0, 4'h0, 7'h00, 7'h0B);
    wr('{GR_BANK, 3'h1, 4'h2}, 4'h5);
    wr('{2'h1, 3'h4, 4'h7}, 4'h9);
    @(posedge core_clk_in);
    mem_ptr_enable_in <= 1'b1;
    ex(OP_MOV_IND_TO, 3'h4, 4'h7, 7'h02, 7'h00);
    chk(mem_addr_out, {2'h1, 3'h3, 4'h5});
    rd('{2'h1, 3'h3, 4'h5});
    chk(d, 4'h9);
    wr('{2'h1, 3'h6, 4'h5}, 4'hC);
    @(posedge core_clk_in);
    mem_ptr_enable_in <= 1'b0;
    ex(OP_MOV_IND_FROM, 3'h6, 4'h0, 7'h02, 7'h00);
    rd('{2'h1, 3'h6, 4'h0});
    chk(d, 4'hC);
    $display("indirect moves finished");
    // a frozen clock enable must swallow the instruction
    @(posedge core_clk_in);
    clk_en_in <= 1'b0;
    ex(OP_ADD, 3'h6, 4'h0, 7'h02, 7'h00);
    chk(done_out, 1'b0);
    clk_en_in <= 1'b1;
    rd('{GR_BANK, 3'h1, 4'h2});
    chk(d, 4'h5);
    @(posedge core_clk_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    #1;
    chk({carry_flag_out, gr_row_pointer_out, bank_out}, 10'h000);
    rd('{GR_BANK, 3'h1, 4'h2});
    chk(d, 4'h5);
    chk({carry_flag_out, gr_row_pointer_out, bank_out}, 10'h000);
    $display("freeze and second reset finished");
    close_out();
  end
endmodule
`default_nettype wire
